// >>> hdl/fspc_ctrl.sv
/*
 * fspc_ctrl: run-time self-programming controller. Holds the control, key, table page and
 * table address registers, the row holding buffer, the unlock sequencer and the operation timer.
 * Assumes a classic Wishbone master for software, and a flash macro that takes one command pulse
 * and returns read data for the current table address combinationally.
 */
`timescale 1ns/1ps
module fspc_ctrl #(
	parameter int unsigned OP_CYCLES_P = fspc_pkg::OP_CYCLES,
	parameter int unsigned ROW_WORDS_P = fspc_pkg::ROW_WORDS
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire fspc_pkg::fspc_wb_req_type wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [23:0] flash_rd_data,
	output fspc_pkg::fspc_flash_cmd_type flash_cmd,
	output logic [23:0] flash_wr_word,
	output logic [23:0] table_address,
	output logic core_stall,
	output logic window_disable
);
	import fspc_pkg::*;

	localparam int unsigned BAW = $clog2(ROW_WORDS_P);

	typedef enum logic [1:0] {
		FSPC_IDLE = 2'b00,
		FSPC_KEY1 = 2'b01,
		FSPC_ARMED = 2'b10
	} fspc_key_type;

	typedef enum logic [1:0] {
		FSPC_READY = 2'b00,
		FSPC_BUSY = 2'b01,
		FSPC_DONE = 2'b10
	} fspc_op_type;

	if (ROW_WORDS_P != ROW_WORDS) begin : g_bad_row
		$error("row size is fixed by the flash array");
	end
	if (OP_CYCLES_P < 2) begin : g_bad_time
		$error("operation time too short");
	end

	fspc_key_type key_state;
	fspc_op_type op_state;
	logic [15:0] control;
	logic [7:0] table_page;
	logic [15:0] table_ea;
	logic [31:0] op_count;
	logic [BAW-1:0] row_fill;
	logic row_fill_bad;
	logic tbl_phase;
	logic [23:0] buf_word;
	fspc_action_type action;
	logic access;
	logic wr_access;
	logic [7:0] adr;
	logic [31:0] wdat;
	logic wr_ctrl;
	logic wr_key;
	logic wr_low;
	logic wr_high;
	logic tbl_access;
	logic start_req;
	logic start_ok;
	logic [23:0] aligned_addr;
	logic [15:0] next_control;
	logic [31:0] next_rdata;

	// nothing is taken while the core is stalled, so no write lands twice
	assign access = wb_req.cyc && wb_req.stb && !wb_ack_o && !core_stall;
	assign wr_access = access && wb_req.we;
	assign adr = wb_req.adr;
	assign wdat = wb_req.dat;
	assign wr_ctrl = wr_access && adr == ADR_CONTROL && wb_req.sel[1];
	assign wr_key = wr_access && adr == ADR_KEY && wb_req.sel[0];
	assign tbl_access = access && (adr == ADR_LOW || adr == ADR_HIGH);
	assign wr_low = wr_access && adr == ADR_LOW && tbl_phase;
	assign wr_high = wr_access && adr == ADR_HIGH && tbl_phase && wb_req.sel[0];
	assign start_req = wr_ctrl && wdat[BIT_START] && !control[BIT_START];
	assign start_ok = start_req && key_state == FSPC_ARMED && wdat[BIT_GATE];

	fspc_op_decode u_decode (
		.erase_select(wdat[BIT_ERASE]),
		.operation_select(wdat[3:0]),
		.action(action)
	);

	fspc_hold_buffer #(
		.DEPTH(ROW_WORDS_P),
		.AW(BAW)
	) u_buffer (
		.sys_clk(sys_clk),
		.reset(reset),
		.wr_low(wr_low),
		.wr_high(wr_high),
		.index(table_ea[BAW:1]),
		.low_data(wdat[15:0]),
		.low_be(wb_req.sel[1:0]),
		.high_data(wdat[7:0]),
		.rd_word(buf_word)
	);

	// two address units per word: page and row offsets are plain low bits
	always_comb begin
		aligned_addr = {table_page, table_ea};
		if (action == FSPC_PAGE_ERASE)
			aligned_addr = {table_page, table_ea} & ~24'(PAGE_WORDS * 2 - 1);
		else if (action == FSPC_ROW_PROG)
			aligned_addr = {table_page, table_ea} & ~24'(ROW_WORDS_P * 2 - 1);
	end

	// unlock sequencer
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			key_state <= FSPC_IDLE;
		end else if (wr_key) begin
			unique case (key_state)
				FSPC_IDLE: key_state <= wdat[7:0] == KEY_FIRST ? FSPC_KEY1 : FSPC_IDLE;
				FSPC_KEY1: begin
					if (wdat[7:0] == KEY_SECOND) key_state <= FSPC_ARMED;
					else key_state <= wdat[7:0] == KEY_FIRST ? FSPC_KEY1 : FSPC_IDLE;
				end
				FSPC_ARMED: key_state <= wdat[7:0] == KEY_FIRST ? FSPC_KEY1 : FSPC_IDLE;
			endcase
		end else if (wr_access && key_state != FSPC_IDLE) begin
			key_state <= FSPC_IDLE;
		end
	end

	// control register: start set-only, fault sticky with set winning
	always_comb begin
		next_control = control;
		if (wr_ctrl) begin
			next_control = (control & ~CONTROL_WMASK) | (wdat[15:0] & CONTROL_WMASK);
			next_control[BIT_FAULT] = wdat[BIT_FAULT] & control[BIT_FAULT];
			next_control[BIT_START] = control[BIT_START];
			if (start_ok && op_state == FSPC_READY) next_control[BIT_START] = 1'b1;
			if (start_req && !start_ok) next_control[BIT_FAULT] = 1'b1;
		end
		if (wr_access && key_state == FSPC_ARMED && !wr_ctrl && !wr_key)
			next_control[BIT_FAULT] = 1'b1;
		if (op_state == FSPC_DONE) next_control[BIT_START] = 1'b0;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) control <= CONTROL_RESET;
		else control <= next_control;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			table_page <= 8'h00;
			table_ea <= 16'h0000;
		end else begin
			if (wr_access && adr == ADR_PAGE && wb_req.sel[0]) table_page <= wdat[7:0];
			if (wr_access && adr == ADR_EA && wb_req.sel[0]) table_ea[7:0] <= wdat[7:0];
			if (wr_access && adr == ADR_EA && wb_req.sel[1]) table_ea[15:8] <= wdat[15:8];
		end
	end

	// row fill tracking; an out-of-order store is remembered and suppresses the flash command of the row start
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			row_fill <= '0;
			row_fill_bad <= 1'b0;
		end else if (op_state == FSPC_DONE) begin
			row_fill <= '0;
			row_fill_bad <= 1'b0;
		end else if (wr_high) begin
			if (table_ea[BAW:1] != row_fill) row_fill_bad <= 1'b1;
			row_fill <= row_fill + 1'b1;
		end
	end

	// table access takes two cycles: window held off for the second one
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tbl_phase <= 1'b0;
			window_disable <= 1'b0;
		end else begin
			tbl_phase <= tbl_access && !tbl_phase;
			window_disable <= tbl_access && !tbl_phase;
		end
	end

	// self-timed operation
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			op_state <= FSPC_READY;
			op_count <= 32'h00000000;
			flash_cmd <= '0;
			core_stall <= 1'b0;
		end else begin
			flash_cmd.start <= 1'b0;
			unique case (op_state)
				FSPC_READY: begin
					if (wr_ctrl && start_ok) begin
						op_state <= FSPC_BUSY;
						op_count <= 32'(OP_CYCLES_P - 1);
						core_stall <= 1'b1;
						flash_cmd.start <= !(action == FSPC_ROW_PROG && row_fill_bad);
						flash_cmd.action <= action;
						flash_cmd.address <= aligned_addr;
					end
				end
				FSPC_BUSY: begin
					if (op_count == 32'h00000001) op_state <= FSPC_DONE;
					op_count <= op_count - 32'h00000001;
				end
				FSPC_DONE: begin
					op_state <= FSPC_READY;
					core_stall <= 1'b0;
				end
				default: op_state <= FSPC_READY;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) flash_wr_word <= 24'h000000;
		else flash_wr_word <= buf_word;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) table_address <= 24'h000000;
		else table_address <= {table_page, table_ea};
	end

	always_comb begin
		next_rdata = 32'h00000000;
		unique case (adr)
			ADR_CONTROL: next_rdata = {16'h0000, control};
			ADR_PAGE: next_rdata = {24'h000000, table_page};
			ADR_EA: next_rdata = {16'h0000, table_ea};
			ADR_LOW: next_rdata = {16'h0000, flash_rd_data[15:0]};
			ADR_HIGH: next_rdata = {24'h000000, flash_rd_data[23:16]};
			ADR_STATUS: next_rdata = {21'h00000, row_fill_bad, key_state, op_state, 6'(row_fill)};
			default: next_rdata = 32'h00000000;
		endcase
	end

	// ack: one cycle for registers, two for table access, held off while stalled
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= access && (!tbl_access || tbl_phase) && !core_stall;
			wb_dat_o <= next_rdata;
		end
	end

	// key pair as this bus delivers it: ack cycle and idle cycle between
	sequence key_pair_s;
		wr_key && wdat[7:0] == KEY_FIRST ##1 !wr_access [*2] ##1 wr_key && wdat[7:0] == KEY_SECOND;
	endsequence

	sequence start_launch_s;
		wr_ctrl && start_ok && op_state == FSPC_READY;
	endsequence

	sequence busy_enter_s;
		core_stall && control[BIT_START] && op_state == FSPC_BUSY ##1 core_stall;
	endsequence

	sequence done_leave_s;
		op_state == FSPC_DONE ##1 !core_stall && !control[BIT_START] && op_state == FSPC_READY;
	endsequence

	property launch_p;
		@(posedge sys_clk) disable iff (reset) start_launch_s |=> busy_enter_s;
	endproperty

	property finish_p;
		@(posedge sys_clk) disable iff (reset) op_state == FSPC_DONE |-> done_leave_s;
	endproperty

	// start, stall and completion
	op_launch_a: assert property (launch_p) else $error("operation did not start");
	op_finish_a: assert property (finish_p) else $error("operation did not finish cleanly");
	start_clears_a: assert property (@(posedge sys_clk) disable iff (reset)
		$fell(control[BIT_START]) |-> $past(op_state) == FSPC_DONE) else $error("start bit cleared early");
	stall_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(core_stall) |-> core_stall [*8]) else $error("stall dropped early");
	stall_len_a: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(core_stall) |-> op_count == 32'(OP_CYCLES_P - 1)) else $error("timer load wrong");
	stall_no_ack_a: assert property (@(posedge sys_clk) disable iff (reset)
		core_stall && $past(core_stall) |-> !wb_ack_o) else $error("bus answered while stalled");
	cmd_origin_a: assert property (@(posedge sys_clk) disable iff (reset)
		flash_cmd.start |-> $past(wr_ctrl) && $past(start_ok)) else $error("flash command without start");

	// unlock and sequence faults
	fault_on_bad_a: assert property (@(posedge sys_clk) disable iff (reset)
		start_req && !start_ok |=> control[BIT_FAULT]) else $error("fault not flagged");
	fault_sticky_a: assert property (@(posedge sys_clk) disable iff (reset)
		control[BIT_FAULT] && !wr_ctrl |=> control[BIT_FAULT]) else $error("fault cleared by itself");
	no_start_lock_a: assert property (@(posedge sys_clk) disable iff (reset)
		start_req && key_state != FSPC_ARMED |=> !control[BIT_START]) else $error("start without unlock");
	gate_inhibit_a: assert property (@(posedge sys_clk) disable iff (reset)
		start_req && !wdat[BIT_GATE] |=> op_state == FSPC_READY) else $error("start with gate low");
	key_arms_a: assert property (@(posedge sys_clk) disable iff (reset)
		key_pair_s |=> key_state == FSPC_ARMED) else $error("keys did not arm");
	key_void_a: assert property (@(posedge sys_clk) disable iff (reset)
		wr_access && !wr_key && key_state != FSPC_IDLE |=> key_state == FSPC_IDLE) else $error("unlock not voided");
	fault_void_a: assert property (@(posedge sys_clk) disable iff (reset)
		wr_access && !wr_key && !wr_ctrl && key_state == FSPC_ARMED |=> control[BIT_FAULT]) else $error("void not flagged");

	// table access and addressing
	window_off_a: assert property (@(posedge sys_clk) disable iff (reset)
		tbl_access && !tbl_phase |=> window_disable) else $error("window not disabled");
	tbl_two_a: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(tbl_access) && !wb_ack_o |=> !wb_ack_o ##1 wb_ack_o) else $error("table access not two cycles");
	ack_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	addr_concat_a: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=> table_address == $past({table_page, table_ea})) else $error("address not concatenated");
	row_align_a: assert property (@(posedge sys_clk) disable iff (reset)
		flash_cmd.start && flash_cmd.action == FSPC_ROW_PROG |-> (flash_cmd.address & 24'(ROW_WORDS_P * 2 - 1)) == 24'h000000)
		else $error("row address not aligned");
	page_align_a: assert property (@(posedge sys_clk) disable iff (reset)
		flash_cmd.start && flash_cmd.action == FSPC_PAGE_ERASE |-> (flash_cmd.address & 24'(PAGE_WORDS * 2 - 1)) == 24'h000000)
		else $error("page address not aligned");
	row_order_a: assert property (@(posedge sys_clk) disable iff (reset)
		wr_high && table_ea[BAW:1] != row_fill |=> row_fill_bad) else $error("out-of-order store not noted");
endmodule : fspc_ctrl

// >>> hdl/fspc_pkg.sv
/*
 * fspc_pkg: constants, register map and carrier types of the flash self-programming controller.
 * Assumes one 20 MHz system clock and a classic Wishbone register slave with 32-bit data.
 */
package fspc_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned OP_TIME_US = 4000;
	localparam int unsigned OP_CYCLES = (CLK_HZ / 1000000) * OP_TIME_US;
	localparam int unsigned ROW_WORDS = 64;
	localparam int unsigned ROW_BYTES = 192;
	localparam int unsigned PAGE_ROWS = 8;
	localparam int unsigned PAGE_WORDS = 512;
	localparam int unsigned PAGE_BYTES = 1536;
	localparam int unsigned TBL_CYCLES = 2;
	localparam logic [7:0] ADR_CONTROL = 8'h00;
	localparam logic [7:0] ADR_KEY = 8'h04;
	localparam logic [7:0] ADR_PAGE = 8'h08;
	localparam logic [7:0] ADR_EA = 8'h0C;
	localparam logic [7:0] ADR_LOW = 8'h10;
	localparam logic [7:0] ADR_HIGH = 8'h14;
	localparam logic [7:0] ADR_STATUS = 8'h18;
	localparam int unsigned BIT_START = 15;
	localparam int unsigned BIT_GATE = 14;
	localparam int unsigned BIT_FAULT = 13;
	localparam int unsigned BIT_ERASE = 6;
	localparam logic [15:0] CONTROL_WMASK = 16'h404F;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam logic [3:0] OP_BULK = 4'hF;
	localparam logic [3:0] OP_GENERAL = 4'hD;
	localparam logic [3:0] OP_SECURE = 4'hC;
	localparam logic [3:0] OP_PAGE = 4'h2;
	localparam logic [3:0] OP_CFG = 4'h0;
	localparam logic [3:0] OP_WORD = 4'h3;
	localparam logic [3:0] OP_ROW = 4'h1;

	typedef enum logic [3:0] {
		FSPC_NONE = 4'h0,
		FSPC_BULK_ERASE = 4'h1,
		FSPC_GENERAL_ERASE = 4'h2,
		FSPC_SECURE_ERASE = 4'h3,
		FSPC_PAGE_ERASE = 4'h4,
		FSPC_CFG_ERASE = 4'h5,
		FSPC_WORD_PROG = 4'h6,
		FSPC_ROW_PROG = 4'h7,
		FSPC_CFG_PROG = 4'h8,
		FSPC_RESERVED = 4'h9
	} fspc_action_type;

	typedef struct packed {
		logic start;
		fspc_action_type action;
		logic [23:0] address;
	} fspc_flash_cmd_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} fspc_wb_req_type;
endpackage : fspc_pkg

// >>> hdl/fspc_op_decode.sv
/*
 * fspc_op_decode: maps erase-select and operation code to a flash action.
 * Assumes pure combinational use inside the controller.
 */
`timescale 1ns/1ps
module fspc_op_decode (
	input wire logic erase_select,
	input wire logic [3:0] operation_select,
	output fspc_pkg::fspc_action_type action
);
	import fspc_pkg::*;

	always_comb begin
		action = FSPC_RESERVED;
		if (erase_select) begin
			unique case (operation_select)
				OP_BULK: action = FSPC_BULK_ERASE;
				OP_GENERAL: action = FSPC_GENERAL_ERASE;
				OP_SECURE: action = FSPC_SECURE_ERASE;
				OP_PAGE: action = FSPC_PAGE_ERASE;
				OP_CFG: action = FSPC_CFG_ERASE;
				OP_WORD, OP_ROW: action = FSPC_NONE;
				default: action = FSPC_RESERVED;
			endcase
		end else begin
			unique case (operation_select)
				OP_WORD: action = FSPC_WORD_PROG;
				OP_ROW: action = FSPC_ROW_PROG;
				OP_CFG: action = FSPC_CFG_PROG;
				OP_BULK, OP_GENERAL, OP_SECURE, OP_PAGE: action = FSPC_NONE;
				default: action = FSPC_RESERVED;
			endcase
		end
	end
endmodule : fspc_op_decode

// >>> hdl/fspc_hold_buffer.sv
/*
 * fspc_hold_buffer: flip-flop holding buffer of one flash row, 24 bits per word.
 * Assumes writes come from the controller, one lane at a time.
 */
`timescale 1ns/1ps
module fspc_hold_buffer #(
	parameter int unsigned DEPTH = 64,
	parameter int unsigned AW = 6
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic wr_low,
	input wire logic wr_high,
	input wire logic [AW-1:0] index,
	input wire logic [15:0] low_data,
	input wire logic [1:0] low_be,
	input wire logic [7:0] high_data,
	output logic [23:0] rd_word
);
	import fspc_pkg::*;

	logic [23:0] mem [DEPTH];

	if (DEPTH != (1 << AW)) begin : g_bad_depth
		$error("depth must equal two to the index width");
	end

	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_word
			always_ff @(posedge sys_clk or posedge reset) begin
				if (reset) begin
					mem[i] <= 24'h000000;
				end else if (index == AW'(i)) begin
					if (wr_low && low_be[0]) mem[i][7:0] <= low_data[7:0];
					if (wr_low && low_be[1]) mem[i][15:8] <= low_data[15:8];
					if (wr_high) mem[i][23:16] <= high_data;
				end
			end
		end
	endgenerate

	assign rd_word = mem[index];
endmodule : fspc_hold_buffer

// >>> tb/fspc_flash_model.sv
/*
 * fspc_flash_model: behavioural flash array facing the controller's flash port.
 * Assumes the controller drives table_address and one-cycle command pulses on sys_clk.
 */
`timescale 1ns/1ps
module fspc_flash_model (
	input wire logic sys_clk,
	input wire fspc_pkg::fspc_flash_cmd_type flash_cmd,
	input wire logic [23:0] table_address,
	output logic [23:0] flash_rd_data,
	output fspc_pkg::fspc_flash_cmd_type last_cmd,
	output int starts
);
	import fspc_pkg::*;
	// array content is a fixed pattern of the word address
	assign flash_rd_data = {table_address[7:0] ^ table_address[23:16], table_address[15:0] ^ 16'h5A3C};
	initial starts = 0;
	always @(posedge sys_clk) begin
		if (flash_cmd.start === 1'b1) begin
			last_cmd <= flash_cmd;
			starts <= starts + 1;
		end
	end
endmodule : fspc_flash_model

// >>> tb/flash_self_programming_ctrl_bench.sv
/*
 * flash_self_programming_ctrl_bench: self-checking bench acting as the core over Wishbone.
 * Assumes the controller of hdl/ with a shortened operation time and the flash model of tb/.
 */
`timescale 1ns/1ps
module flash_self_programming_ctrl_bench;
	import fspc_pkg::*;
	localparam int unsigned OPC = 20;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	fspc_wb_req_type wb_req = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [23:0] flash_rd_data;
	logic [23:0] flash_wr_word;
	logic [23:0] table_address;
	fspc_flash_cmd_type flash_cmd;
	fspc_flash_cmd_type last_cmd;
	logic core_stall;
	logic window_disable;
	int starts;
	int err_total = 0;
	int n_checks = 0;
	int cyc_n = 0;
	int stall_len = 0;
	int stall_run = 0;
	int win_n = 0;
	int seed = 55;
	logic [31:0] q;
	logic [31:0] lo_d;
	logic [31:0] hi_d;
	logic [7:0] pg = 8'h00;
	logic [15:0] ea = 16'h0000;
	logic [3:0] codes [9] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'h3, 4'h2, 4'h1, 4'h0};

	always #25 sys_clk = ~sys_clk;

	fspc_ctrl #(.OP_CYCLES_P(OPC)) dut (.sys_clk(sys_clk), .reset(reset), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .flash_rd_data(flash_rd_data), .flash_cmd(flash_cmd), .flash_wr_word(flash_wr_word),
		.table_address(table_address), .core_stall(core_stall), .window_disable(window_disable));
	fspc_flash_model flash (.sys_clk(sys_clk), .flash_cmd(flash_cmd), .table_address(table_address),
		.flash_rd_data(flash_rd_data), .last_cmd(last_cmd), .starts(starts));

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	// stall length, window pulses and the hang limit
	always @(posedge sys_clk) begin
		cyc_n <= cyc_n + 1;
		if (window_disable === 1'b1) win_n <= win_n + 1;
		if (core_stall === 1'b1) stall_run <= stall_run + 1;
		else if (stall_run != 0) begin
			stall_len <= stall_run;
			stall_run <= 0;
		end
		if (cyc_n == 40000) begin
			err_total++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// waits for ack however long; only the cycle limit ends a hang
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
		@(posedge sys_clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
		do begin
			@(posedge sys_clk);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_req <= '0;
	endtask : wb

	function automatic fspc_action_type act_of(input logic er, input logic [3:0] c);
		case ({er, c})
			5'h1F: return FSPC_BULK_ERASE;
			5'h1D: return FSPC_GENERAL_ERASE;
			5'h1C: return FSPC_SECURE_ERASE;
			5'h12: return FSPC_PAGE_ERASE;
			5'h10: return FSPC_CFG_ERASE;
			5'h03: return FSPC_WORD_PROG;
			5'h01: return FSPC_ROW_PROG;
			5'h00: return FSPC_CFG_PROG;
			5'h1E, 5'h1B, 5'h0E, 5'h0B: return FSPC_RESERVED;
			default: return FSPC_NONE;
		endcase
	endfunction : act_of

	// mode 0 proper, 1 no keys, 2 write between keys, 3 keys swapped
	task automatic run(input logic [15:0] ctl, input int mode);
		int s0;
		bit ok;
		fspc_action_type act;
		s0 = starts;
		act = act_of(ctl[6], ctl[3:0]);
		ok = (mode == 0) && ctl[14];
		wb(1'b1, ADR_CONTROL, {16'h0, ctl});
		if (mode != 1) wb(1'b1, ADR_KEY, {24'h0, (mode == 3) ? KEY_SECOND : KEY_FIRST});
		if (mode == 2) wb(1'b1, ADR_PAGE, {24'h0, pg});
		if (mode != 1) wb(1'b1, ADR_KEY, {24'h0, (mode == 3) ? KEY_FIRST : KEY_SECOND});
		wb(1'b1, ADR_CONTROL, {16'h0, ctl | 16'h8000});
		wb(1'b0, ADR_CONTROL, 32'h0);
		chk(q, {16'h0, (ctl & CONTROL_WMASK) | (ok ? 16'h0 : 16'h2000)}, "control after start");
		if (!ok) chk(starts - s0, 0, "refused start");
		else begin
			chk((starts > s0) ? last_cmd.action : FSPC_NONE, act, "action");
			chk(stall_len, OPC, "stall length");
			if (act == FSPC_PAGE_ERASE) chk(last_cmd.address, {pg, ea} & 24'hFFFC00, "page");
			if (act == FSPC_ROW_PROG) chk(last_cmd.address, {pg, ea} & 24'hFFFF80, "row");
		end
	endtask : run

	initial begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		wb(1'b0, ADR_CONTROL, 32'h0);
		chk(q, {16'h0, CONTROL_RESET}, "control reset");
		wb(1'b1, ADR_KEY, {24'h0, KEY_FIRST});
		wb(1'b0, ADR_KEY, 32'h0);
		chk(q, 32'h0, "key reads zero");
		wb(1'b1, 8'hFC, 32'hFFFFFFFF);
		wb(1'b0, 8'hFC, 32'h0);
		chk(q, 32'h0, "unmapped");
		pg = 8'($random(seed));
		ea = 16'($random(seed));
		wb(1'b1, ADR_PAGE, {24'h0, pg});
		wb(1'b1, ADR_EA, {16'h0, ea});
		@(posedge sys_clk);
		chk({8'h0, table_address}, {8'h0, pg, ea}, "table address");
		for (int k = 0; k < 2; k++) begin
			wb(1'b0, k ? ADR_HIGH : ADR_LOW, 32'h0);
			chk(q, k ? {24'h0, ea[7:0] ^ pg} : {16'h0, ea ^ 16'h5A3C}, "table read");
		end
		chk(win_n, 2, "window disabled per access");
		for (int e = 0; e < 2; e++)
			for (int i = 0; i < 9; i++)
				if (!(e == 0 && codes[i] == OP_ROW)) run({9'h080, e[0], 2'b0, codes[i]}, 0);
		for (int m = 1; m < 4; m++) run(16'h4042, m);
		run(16'h0042, 0);
		ea = ea & 16'hFF80;
		for (int i = 0; i < ROW_WORDS; i++) begin
			lo_d = $random(seed);
			hi_d = $random(seed);
			wb(1'b1, ADR_EA, {16'h0, ea + 16'(2 * i)});
			wb(1'b1, ADR_LOW, lo_d);
			wb(1'b1, ADR_HIGH, hi_d);
			@(posedge sys_clk);
			chk({8'h0, flash_wr_word}, {8'h0, hi_d[7:0], lo_d[15:0]}, "buffer word");
		end
		chk(starts, 17, "no flash command from table stores");
		run(16'h4001, 0);
		summarize();
	end
endmodule : flash_self_programming_ctrl_bench
